/* File: pkg/eex_pkg.sv */
// Shared constants for the error exit recorder and exchange flag field
package eex_pkg;
   // Geometry
   localparam int EEX_NCOND   = 6;
   localparam int EEX_ADDR_W  = 21;
   localparam int EEX_MON_W   = 16;
   localparam int EEX_CODE_W  = 6;
   localparam int EEX_FLAG_W  = 6;
   localparam int EEX_WORD_W  = 60;
   localparam int EEX_CMU_W   = 32;
   // Flag field position inside the fourth exchange package word
   localparam int EEX_XP_FLAG_WORD = 3;
   localparam int EEX_XP_FLAG_LSB  = 51;
   localparam int EEX_XP_FLAG_MSB  = 56;
   // Flag register bits (bit 5 holds package bit 56)
   localparam int EEX_FLG_UEM   = 5;
   localparam int EEX_FLG_RSV   = 4;
   localparam int EEX_FLG_BLK   = 3;
   localparam int EEX_FLG_CIF   = 2;
   localparam int EEX_FLG_PURGE = 1;
   localparam int EEX_FLG_HWE   = 0;
   // Block copy address slice of index register zero
   localparam int EEX_BLK_LSB = 30;
   localparam int EEX_BLK_MSB = 50;
   // Firmware exit codes (octal 00, 20 and 67)
   localparam logic [EEX_CODE_W-1:0] EEX_CODE_SW   = 6'h00;
   localparam logic [EEX_CODE_W-1:0] EEX_CODE_HW_A = 6'h10;
   localparam logic [EEX_CODE_W-1:0] EEX_CODE_HW_B = 6'h37;
   // Register byte offsets
   localparam logic [7:0] EEX_OFF_EMS   = 8'h00;
   localparam logic [7:0] EEX_OFF_FLAGS = 8'h04;
   localparam logic [7:0] EEX_OFF_PEND  = 8'h08;
   localparam logic [7:0] EEX_OFF_RADDR = 8'h0c;
   localparam logic [7:0] EEX_OFF_RCOND = 8'h10;
   localparam logic [7:0] EEX_OFF_RMON  = 8'h14;
   localparam logic [7:0] EEX_OFF_CRA   = 8'h18;
   localparam logic [7:0] EEX_OFF_CFL   = 8'h1c;
   // Reset values
   localparam logic [EEX_FLAG_W-1:0] EEX_FLAGS_RST = 6'h00;
   localparam logic [EEX_NCOND-1:0]  EEX_EMS_RST   = 6'h00;
   localparam logic [31:0]           EEX_RD_ZERO   = 32'h0000_0000;
   // Field position of the code inside the condition readback
   localparam int EEX_RCOND_CODE_LSB = 16;
endpackage

/* File: src/eex_pending.sv */
// Store of exit condition bits that occurred without exit mode selected
module eex_pending
   import eex_pkg::*;
#(
   parameter int NCOND = EEX_NCOND
)(
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic [NCOND-1:0] set_bits,
   input  wire logic             flush,
   output logic      [NCOND-1:0] pend
);
   logic [NCOND-1:0] pend_r;
   logic [NCOND-1:0] pend_nxt;

   // New arrival beats a flush in the same cycle
   genvar i;
   generate
      for (i = 0; i < NCOND; i++)
      begin : g_bit
         assign pend_nxt[i] = set_bits[i] | (pend_r[i] & ~flush); // [RULE_03] [RULE_19]
      end
   endgenerate

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         pend_r <= '0;
      else
         pend_r <= pend_nxt;
   end

   assign pend = pend_r;
endmodule

/* File: src/eex_flags.sv */
// Exchange package flag register with hardware set and clear paths
module eex_flags
   import eex_pkg::*;
#(
   parameter int CMU_W = EEX_CMU_W
)(
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire logic                  wr_en,
   input  wire logic [EEX_FLAG_W-1:0] wr_data,
   input  wire logic                  hwe_set,
   input  wire logic                  cmu_intr,
   input  wire logic [CMU_W-1:0]      cmu_state,
   input  wire logic                  cmu_resume,
   output logic      [EEX_FLAG_W-1:0] flags,
   output logic      [CMU_W-1:0]      saved_state
);
   logic [EEX_FLAG_W-1:0] flags_r;
   logic [EEX_FLAG_W-1:0] flags_nxt;
   logic [EEX_FLAG_W-1:0] hw_set;
   logic [EEX_FLAG_W-1:0] hw_clr;
   logic [EEX_FLAG_W-1:0] keep;
   logic [CMU_W-1:0]      saved_r;

   assign hw_set = (EEX_FLAG_W'(hwe_set) << EEX_FLG_HWE)    // [RULE_20]
                 | (EEX_FLAG_W'(cmu_intr) << EEX_FLG_CIF);  // [RULE_15]
   // Resume consumes the interrupted mark
   assign hw_clr = EEX_FLAG_W'(cmu_resume) << EEX_FLG_CIF; // [RULE_16]

   // Hardware sets win over software writes and resume clears
   genvar i;
   generate
      for (i = 0; i < EEX_FLAG_W; i++)
      begin : g_flag
         if (i == EEX_FLG_RSV)
         begin : g_rsv
            assign flags_nxt[i] = 1'b0; // [RULE_12]
         end
         else
         begin : g_rw
            assign keep[i] = wr_en ? wr_data[i] : flags_r[i];
            assign flags_nxt[i] = hw_set[i] | (keep[i] & ~hw_clr[i]); // [RULE_11]
         end
      end
   endgenerate
   assign keep[EEX_FLG_RSV] = 1'b0;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         flags_r <= EEX_FLAGS_RST;
      else
         flags_r <= flags_nxt;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         saved_r <= '0;
      else if (cmu_intr)
         saved_r <= cmu_state; // [RULE_15]
   end

   assign flags       = flags_r;
   assign saved_state = saved_r;
endmodule

/* File: src/eex_top.sv */
// Error exit recorder and exchange package flag field with APB registers
// Function
// [RULE_01] Firmware-handled errors record program address and exit code in reference word.
// [RULE_02] Enabled exit condition takes error exit, recording its condition code; the design takes none when a firmware exchange comes in the same cycle.
// [RULE_03] Disabled exit condition lets execution continue and stays pending.
// [RULE_04] Error exit records all pending bits with the causing bit.
// [RULE_05] Exchange to error firmware discards pending condition bits.
// [RULE_06] Every firmware-handled software error records code 00; the design records 20 or 67 instead when hw_err comes in the same cycle.
// [RULE_07] Firmware-handled hardware errors record only code 20 or 67.
// [RULE_08] Monitor diagnostic bits go in low 16 bits of reference word.
// [RULE_09] Reference address and field length registers are 21 bits.
// [RULE_10] Fourth exchange package word holds a 6-bit flag field.
// [RULE_11] Flags at bits 56..51: memory enable, copy, interrupted, purge, error.
// [RULE_12] Software writes zero to reserved flag bit 55.
// [RULE_13] Extended memory instructions illegal unless memory enable flag set.
// [RULE_14] Block copy flag takes address from index register zero bits 30..50.
// [RULE_15] Interrupted compare/move sets its flag and saves resume state.
// [RULE_16] Refetch with interrupted flag set resumes from saved point.
// [RULE_17] Purge flag requests extended lookahead stack purging.
// [RULE_18] Hardware error exits are always enabled.
// [RULE_19] Pending store clears once written out or discarded.
// [RULE_20] Hardware error exchange sets the hardware error flag.
module eex_top
   import eex_pkg::*;
#(
   parameter int NCOND = EEX_NCOND,
   parameter int CMU_W = EEX_CMU_W
)(
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [EEX_ADDR_W-1:0] prog_addr,
   input  wire logic [NCOND-1:0]      cond_evt,
   input  wire logic                  xchg_req,
   input  wire logic                  sw_err,
   input  wire logic                  hw_err,
   input  wire logic                  hw_err_alt,
   input  wire logic [EEX_MON_W-1:0]  monitor_condition_bits,
   input  wire logic                  cmu_intr,
   input  wire logic [CMU_W-1:0]      cmu_state,
   input  wire logic                  cmu_refetch,
   input  wire logic [EEX_WORD_W-1:0] index_register_zero,
   input  wire logic [EEX_ADDR_W-1:0] address_register_zero,
   output logic                       rec_valid,
   output logic                       err_exit,
   output logic                       fw_exchange,
   output logic [EEX_ADDR_W-1:0]      rec_addr,
   output logic [NCOND-1:0]           rec_cond,
   output logic [EEX_CODE_W-1:0]      rec_code,
   output logic [EEX_MON_W-1:0]       rec_mon,
   output logic [EEX_WORD_W-1:0]      xp_flag_word,
   output logic [EEX_ADDR_W-1:0]      central_reference_address,
   output logic [EEX_ADDR_W-1:0]      central_field_length,
   output logic                       ext_mem_illegal,
   output logic [EEX_ADDR_W-1:0]      blk_copy_addr,
   output logic                       purge_ext,
   output logic                       cmu_resume,
   output logic [CMU_W-1:0]           cmu_resume_state
);
   generate
      if (NCOND < 1 || NCOND > EEX_RCOND_CODE_LSB)
      begin : g_bad_ncond
         $error("NCOND must lie between 1 and 16");
      end
      if (CMU_W < 1 || CMU_W > 32)
      begin : g_bad_cmu
         $error("CMU_W must lie between 1 and 32");
      end
   endgenerate

   // Bus phases
   wire                    setup;
   wire                    access;
   wire                    wr;
   wire                    hit;
   wire [31:0]             rd_mux;
   // Event decode
   wire                    fw;
   wire                    exit_hit;
   wire [NCOND-1:0]        ems_hit;
   wire [NCOND-1:0]        pend_set;
   wire [NCOND-1:0]        pend;
   wire                    pend_flush;
   wire [EEX_CODE_W-1:0]   fw_code;
   wire                    resume_go;
   wire [EEX_FLAG_W-1:0]   flags;
   wire [CMU_W-1:0]        saved_state;
   wire                    flag_wr;

   logic [NCOND-1:0]       exit_mode_selection_r;
   logic [EEX_ADDR_W-1:0]  cra_r;
   logic [EEX_ADDR_W-1:0]  cfl_r;
   logic [31:0]            prdata_r;
   logic                   pready_r;
   logic                   pslverr_r;
   logic                   rec_valid_r;
   logic                   err_exit_r;
   logic                   fw_exchange_r;
   logic [EEX_ADDR_W-1:0]  rec_addr_r;
   logic [NCOND-1:0]       rec_cond_r;
   logic [EEX_CODE_W-1:0]  rec_code_r;
   logic [EEX_MON_W-1:0]   rec_mon_r;
   logic [EEX_WORD_W-1:0]  xp_word_r;
   logic                   ext_mem_illegal_r;
   logic [EEX_ADDR_W-1:0]  blk_addr_r;
   logic                   purge_ext_r;
   logic                   cmu_resume_r;
   logic [CMU_W-1:0]       cmu_resume_state_r;

   // APB: zero-wait access, answer registered at the setup edge
   assign setup  = psel & ~penable;
   assign access = psel & penable & pready_r;
   assign wr     = access & pwrite;
   assign hit    = (paddr == EEX_OFF_EMS)   | (paddr == EEX_OFF_FLAGS)
                 | (paddr == EEX_OFF_PEND)  | (paddr == EEX_OFF_RADDR)
                 | (paddr == EEX_OFF_RCOND) | (paddr == EEX_OFF_RMON)
                 | (paddr == EEX_OFF_CRA)   | (paddr == EEX_OFF_CFL);
   assign rd_mux =
        (paddr == EEX_OFF_EMS)   ? 32'(exit_mode_selection_r)
      : (paddr == EEX_OFF_FLAGS) ? 32'(flags)
      : (paddr == EEX_OFF_PEND)  ? 32'(pend)
      : (paddr == EEX_OFF_RADDR) ? 32'(rec_addr_r)
      : (paddr == EEX_OFF_RCOND) ? (32'(rec_cond_r)
                                   | (32'(rec_code_r) << EEX_RCOND_CODE_LSB))
      : (paddr == EEX_OFF_RMON)  ? 32'(rec_mon_r)
      : (paddr == EEX_OFF_CRA)   ? 32'(cra_r)
      : (paddr == EEX_OFF_CFL)   ? 32'(cfl_r)
      : EEX_RD_ZERO;
   assign flag_wr = wr & (paddr == EEX_OFF_FLAGS);

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= EEX_RD_ZERO;
      end
      else
      begin
         pready_r  <= setup;
         pslverr_r <= setup & ~hit;
         prdata_r  <= (setup & ~pwrite) ? rd_mux : EEX_RD_ZERO;
      end
   end

   // Software-owned configuration
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         exit_mode_selection_r <= EEX_EMS_RST;
         cra_r                 <= '0;
         cfl_r                 <= '0;
      end
      else if (wr)
      begin
         if (paddr == EEX_OFF_EMS)
            exit_mode_selection_r <= pwdata[NCOND-1:0];
         if (paddr == EEX_OFF_CRA)
            cra_r <= pwdata[EEX_ADDR_W-1:0]; // [RULE_09]
         if (paddr == EEX_OFF_CFL)
            cfl_r <= pwdata[EEX_ADDR_W-1:0]; // [RULE_09]
      end
   end

   // Firmware exchange outranks an error exit in the same cycle
   assign fw        = hw_err | sw_err | xchg_req;
   assign ems_hit   = cond_evt & exit_mode_selection_r;
   assign exit_hit  = (|ems_hit) & ~fw; // [RULE_02]
   // Hardware errors never consult the mode bits
   assign fw_code   = hw_err ? (hw_err_alt ? EEX_CODE_HW_B : EEX_CODE_HW_A) // [RULE_07] [RULE_18]
                    : EEX_CODE_SW; // [RULE_06]
   assign pend_flush = exit_hit | fw; // [RULE_05] [RULE_19]
   // Bits seen in an exit cycle leave with the exit, not into the store
   assign pend_set  = exit_hit ? '0 : (cond_evt & ~exit_mode_selection_r); // [RULE_03]

   eex_pending #(
      .NCOND (NCOND)
   ) u_pend (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .set_bits (pend_set),
      .flush    (pend_flush),
      .pend     (pend)
   );

   // Record of the last exit
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         rec_valid_r   <= 1'b0;
         err_exit_r    <= 1'b0;
         fw_exchange_r <= 1'b0;
         rec_addr_r    <= '0;
         rec_cond_r    <= '0;
         rec_code_r    <= EEX_CODE_SW;
         rec_mon_r     <= '0;
      end
      else
      begin
         rec_valid_r   <= exit_hit | hw_err | sw_err;
         err_exit_r    <= exit_hit;
         fw_exchange_r <= fw;
         if (exit_hit)
         begin
            rec_addr_r <= prog_addr;
            rec_cond_r <= cond_evt | pend; // [RULE_02] [RULE_04]
            rec_code_r <= EEX_CODE_SW;
            rec_mon_r  <= '0;
         end
         else if (hw_err | sw_err)
         begin
            rec_addr_r <= prog_addr;        // [RULE_01]
            rec_cond_r <= '0;               // [RULE_05]
            rec_code_r <= fw_code;          // [RULE_01]
            rec_mon_r  <= monitor_condition_bits; // [RULE_08]
         end
      end
   end

   assign resume_go = cmu_refetch & flags[EEX_FLG_CIF]; // [RULE_16]

   eex_flags #(
      .CMU_W (CMU_W)
   ) u_flags (
      .ref_clk     (ref_clk),
      .rst         (rst),
      .wr_en       (flag_wr),
      .wr_data     (pwdata[EEX_FLAG_W-1:0]),
      .hwe_set     (hw_err),
      .cmu_intr    (cmu_intr),
      .cmu_state   (cmu_state),
      .cmu_resume  (resume_go),
      .flags       (flags),
      .saved_state (saved_state)
   );

   // Flag-steered execution controls, registered for clean outputs
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         xp_word_r          <= '0;
         ext_mem_illegal_r  <= 1'b1;
         blk_addr_r         <= '0;
         purge_ext_r        <= 1'b0;
         cmu_resume_r       <= 1'b0;
         cmu_resume_state_r <= '0;
      end
      else
      begin
         xp_word_r <= EEX_WORD_W'(flags) << EEX_XP_FLAG_LSB; // [RULE_10] [RULE_11]
         ext_mem_illegal_r <= ~flags[EEX_FLG_UEM]; // [RULE_13]
         blk_addr_r <= flags[EEX_FLG_BLK]
                     ? index_register_zero[EEX_BLK_MSB:EEX_BLK_LSB] // [RULE_14]
                     : address_register_zero;
         purge_ext_r  <= flags[EEX_FLG_PURGE]; // [RULE_17]
         cmu_resume_r <= resume_go; // [RULE_16]
         if (resume_go)
            cmu_resume_state_r <= saved_state;
      end
   end

   assign prdata                    = prdata_r;
   assign pready                    = pready_r;
   assign pslverr                   = pslverr_r;
   assign rec_valid                 = rec_valid_r;
   assign err_exit                  = err_exit_r;
   assign fw_exchange               = fw_exchange_r;
   assign rec_addr                  = rec_addr_r;
   assign rec_cond                  = rec_cond_r;
   assign rec_code                  = rec_code_r;
   assign rec_mon                   = rec_mon_r;
   assign xp_flag_word              = xp_word_r;
   assign central_reference_address = cra_r;
   assign central_field_length      = cfl_r;
   assign ext_mem_illegal           = ext_mem_illegal_r;
   assign blk_copy_addr             = blk_addr_r;
   assign purge_ext                 = purge_ext_r;
   assign cmu_resume                = cmu_resume_r;
   assign cmu_resume_state          = cmu_resume_state_r;
endmodule

/* File: dv/eex_top_sva.sv */
// Assertion checker for the error exit recorder ports
module eex_top_sva
   import eex_pkg::*;
#(
   parameter int NCOND = EEX_NCOND,
   parameter int CMU_W = EEX_CMU_W
)(
   input wire logic                  ref_clk,
   input wire logic                  rst,
   input wire logic [EEX_ADDR_W-1:0] prog_addr,
   input wire logic                  sw_err,
   input wire logic                  hw_err,
   input wire logic                  hw_err_alt,
   input wire logic [EEX_MON_W-1:0]  monitor_condition_bits,
   input wire logic                  cmu_intr,
   input wire logic                  cmu_refetch,
   input wire logic [EEX_WORD_W-1:0] index_register_zero,
   input wire logic [EEX_ADDR_W-1:0] address_register_zero,
   input wire logic                  rec_valid,
   input wire logic                  err_exit,
   input wire logic                  fw_exchange,
   input wire logic [EEX_ADDR_W-1:0] rec_addr,
   input wire logic [EEX_CODE_W-1:0] rec_code,
   input wire logic [EEX_MON_W-1:0]  rec_mon,
   input wire logic [EEX_WORD_W-1:0] xp_flag_word,
   input wire logic                  ext_mem_illegal,
   input wire logic [EEX_ADDR_W-1:0] blk_copy_addr,
   input wire logic                  cmu_resume
);
   // Two edges out of reset before event checks, the first edge still looks like reset
   logic [1:0] live_r;
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         live_r <= 2'h0;
      else
         live_r <= {live_r[0], 1'b1};
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_sw_code;
      live_r[1] && sw_err && !hw_err |=> rec_valid && fw_exchange && rec_code == EEX_CODE_SW;
   endproperty
   a_sw_code: assert property (p_sw_code) else $error("software error record wrong");
   property p_hw_code;
      live_r[1] && hw_err && !sw_err |=> fw_exchange
         && rec_code == ($past(hw_err_alt) ? EEX_CODE_HW_B : EEX_CODE_HW_A);
   endproperty
   a_hw_code: assert property (p_hw_code) else $error("hardware error code wrong");
   property p_hw_flag;
      live_r[1] && hw_err |-> ##2 xp_flag_word[EEX_XP_FLAG_LSB];
   endproperty
   a_hw_flag: assert property (p_hw_flag) else $error("hardware error flag not set");
   property p_record;
      live_r[1] && (sw_err || hw_err) |=> rec_addr == $past(prog_addr)
         && rec_mon == $past(monitor_condition_bits);
   endproperty
   a_record: assert property (p_record) else $error("record address or monitor wrong");
   property p_exit;
      err_exit |-> rec_valid && !fw_exchange && rec_mon == '0;
   endproperty
   a_exit: assert property (p_exit) else $error("error exit record wrong");
   property p_flag_pos;
      (xp_flag_word & ~60'h178_0000_0000_0000) == '0;
   endproperty
   a_flag_pos: assert property (p_flag_pos) else $error("flag word bit out of field");
   property p_mem_gate;
      ext_mem_illegal == !xp_flag_word[EEX_XP_FLAG_MSB];
   endproperty
   a_mem_gate: assert property (p_mem_gate) else $error("memory gate mismatch");
   property p_blk;
      live_r[1] |-> blk_copy_addr == (xp_flag_word[54]
         ? $past(index_register_zero[EEX_BLK_MSB:EEX_BLK_LSB]) : $past(address_register_zero));
   endproperty
   a_blk: assert property (p_blk) else $error("block copy address wrong");
   property p_cif;
      live_r[1] && cmu_intr |-> ##2 xp_flag_word[53];
   endproperty
   a_cif: assert property (p_cif) else $error("interrupted flag not set");
   property p_resume;
      cmu_resume |-> $past(cmu_refetch);
   endproperty
   a_resume: assert property (p_resume) else $error("resume without refetch");
   c_exit: cover property (err_exit);
   c_hw_alt: cover property (fw_exchange && rec_code == EEX_CODE_HW_B);
   c_resume: cover property (cmu_resume);
endmodule
bind eex_top eex_top_sva #(.NCOND(NCOND), .CMU_W(CMU_W)) u_sva (
   .ref_clk(ref_clk), .rst(rst), .prog_addr(prog_addr), .sw_err(sw_err), .hw_err(hw_err),
   .hw_err_alt(hw_err_alt), .monitor_condition_bits(monitor_condition_bits),
   .cmu_intr(cmu_intr), .cmu_refetch(cmu_refetch), .index_register_zero(index_register_zero),
   .address_register_zero(address_register_zero), .rec_valid(rec_valid), .err_exit(err_exit),
   .fw_exchange(fw_exchange), .rec_addr(rec_addr), .rec_code(rec_code), .rec_mon(rec_mon),
   .xp_flag_word(xp_flag_word), .ext_mem_illegal(ext_mem_illegal),
   .blk_copy_addr(blk_copy_addr), .cmu_resume(cmu_resume));

/* File: dv/testbench.sv */
// Self-checking testbench for the error exit recorder and flag field
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import eex_pkg::*;
   typedef struct {
      logic [7:0]  a;
      logic [31:0] w;
      logic [31:0] r;
      logic        e;
   } eex_row_s;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [20:0] prog_addr = 21'h1f_0f0f;
   logic [5:0]  cond_evt = 6'h00;
   logic        xchg_req = 1'b0;
   logic        sw_err = 1'b0;
   logic        hw_err = 1'b0;
   logic        hw_err_alt = 1'b0;
   logic [15:0] mon = 16'hbeef;
   logic        cmu_intr = 1'b0;
   logic [31:0] cmu_state = 32'h1234_5678;
   logic        cmu_refetch = 1'b0;
   logic [59:0] irz = 60'h0ab_cdef_1234_5678;
   logic [20:0] arz = 21'h15_5aa5;
   logic [31:0] prdata, cmu_resume_state, rd;
   logic        pready, pslverr, rec_valid, err_exit, fw_exchange, er;
   logic        ext_mem_illegal, purge_ext, cmu_resume;
   logic [20:0] rec_addr, cra, cfl, blk_copy_addr;
   logic [5:0]  rec_cond, rec_code;
   logic [15:0] rec_mon;
   logic [59:0] xp_flag_word;
   int          failures = 0;
   int          checks = 0;
   // Unmapped and read-only places sit beside the writable ones
   eex_row_s rows [8] = '{
      '{EEX_OFF_EMS, 32'hffff_ffff, 32'h0000_003f, 1'b0},
      '{EEX_OFF_FLAGS, 32'hffff_ffef, 32'h0000_002f, 1'b0},
      '{EEX_OFF_FLAGS, 32'h0000_0000, 32'h0000_0000, 1'b0},
      '{EEX_OFF_CRA, 32'hffff_ffff, 32'h001f_ffff, 1'b0},
      '{EEX_OFF_CFL, 32'h0012_3456, 32'h0012_3456, 1'b0},
      '{EEX_OFF_PEND, 32'h0000_003f, 32'h0000_0000, 1'b0},
      '{EEX_OFF_RADDR, 32'hffff_ffff, 32'h0000_0000, 1'b0},
      '{8'h20, 32'hffff_ffff, 32'h0000_0000, 1'b1}};
   eex_top u_dut (
      .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .prog_addr(prog_addr), .cond_evt(cond_evt), .xchg_req(xchg_req), .sw_err(sw_err),
      .hw_err(hw_err), .hw_err_alt(hw_err_alt), .monitor_condition_bits(mon),
      .cmu_intr(cmu_intr), .cmu_state(cmu_state), .cmu_refetch(cmu_refetch),
      .index_register_zero(irz), .address_register_zero(arz), .rec_valid(rec_valid),
      .err_exit(err_exit), .fw_exchange(fw_exchange), .rec_addr(rec_addr),
      .rec_cond(rec_cond), .rec_code(rec_code), .rec_mon(rec_mon),
      .xp_flag_word(xp_flag_word), .central_reference_address(cra),
      .central_field_length(cfl), .ext_mem_illegal(ext_mem_illegal),
      .blk_copy_addr(blk_copy_addr), .purge_ext(purge_ext), .cmu_resume(cmu_resume),
      .cmu_resume_state(cmu_resume_state));
   always #4 ref_clk = ~ref_clk;
   task automatic summarize;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
      checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Bus cycle; pready and read data are taken at the same edge
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] w);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= w;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         failures++;
         summarize();
      end
   endtask
   // One-cycle event pulse; k is refetch, interrupt, hw, sw, exchange
   task automatic ev(logic [5:0] c, logic [4:0] k);
      @(posedge ref_clk);
      cond_evt <= c;
      {cmu_refetch, cmu_intr, hw_err, sw_err, xchg_req} <= k;
      @(posedge ref_clk);
      cond_evt <= 6'h00;
      {cmu_refetch, cmu_intr, hw_err, sw_err, xchg_req} <= 5'h00;
      #1;
   endtask
   task automatic lag;
      @(posedge ref_clk);
      #1;
   endtask
   initial
   begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      apb(1'b0, EEX_OFF_FLAGS, 32'h0000_0000);
      chk("flags reset", rd, 32'h0000_0000);
      chk("gate reset", ext_mem_illegal, 1'b1);
      foreach (rows[i])
      begin
         apb(1'b1, rows[i].a, rows[i].w);
         chk("wr err", er, rows[i].e);
         apb(1'b0, rows[i].a, 32'h0000_0000);
         chk("rd data", rd, rows[i].r);
         chk("rd err", er, rows[i].e);
      end
      chk("cra", cra, 21'h1f_ffff);
      chk("cfl", cfl, 21'h12_3456);
      apb(1'b1, EEX_OFF_FLAGS, 32'h0000_002f);
      lag();
      chk("flag word", xp_flag_word, 60'h178_0000_0000_0000);
      chk("gate", ext_mem_illegal, 1'b0);
      chk("purge", purge_ext, 1'b1);
      chk("blk x0", blk_copy_addr, irz[EEX_BLK_MSB:EEX_BLK_LSB]);
      apb(1'b1, EEX_OFF_FLAGS, 32'h0000_0000);
      lag();
      chk("blk a0", blk_copy_addr, arz);
      chk("gate off", ext_mem_illegal, 1'b1);
      apb(1'b1, EEX_OFF_EMS, 32'h0000_0002);
      ev(6'h01, 5'h00);
      chk("no exit", err_exit, 1'b0);
      ev(6'h02, 5'h00);
      chk("exit", err_exit, 1'b1);
      chk("exit cond", rec_cond, 6'h03);
      chk("exit mon", rec_mon, 16'h0000);
      apb(1'b0, EEX_OFF_RCOND, 32'h0000_0000);
      chk("exit cond reg", rd, {10'h000, EEX_CODE_SW, 16'h0003});
      apb(1'b0, EEX_OFF_PEND, 32'h0000_0000);
      chk("pend out", rd, 32'h0000_0000);
      apb(1'b1, EEX_OFF_EMS, 32'h0000_0000);
      ev(6'h04, 5'h00);
      apb(1'b0, EEX_OFF_PEND, 32'h0000_0000);
      chk("pend held", rd, 32'h0000_0004);
      ev(6'h00, 5'h01);
      chk("xchg", fw_exchange, 1'b1);
      chk("xchg no rec", rec_valid, 1'b0);
      apb(1'b0, EEX_OFF_PEND, 32'h0000_0000);
      chk("pend gone", rd, 32'h0000_0000);
      ev(6'h00, 5'h02);
      chk("sw rec", rec_valid, 1'b1);
      chk("sw code", rec_code, EEX_CODE_SW);
      chk("sw addr", rec_addr, prog_addr);
      chk("sw mon", rec_mon, mon);
      apb(1'b0, EEX_OFF_RMON, 32'h0000_0000);
      chk("mon reg", rd, {16'h0000, mon});
      for (int a = 0; a < 2; a++)
      begin
         hw_err_alt <= a[0];
         prog_addr <= prog_addr + 21'h00_0001;
         ev(6'h00, 5'h04);
         chk("hw exch", fw_exchange, 1'b1);
         chk("hw code", rec_code, a ? EEX_CODE_HW_B : EEX_CODE_HW_A);
         chk("hw addr", rec_addr, prog_addr);
         lag();
         chk("hw flag", xp_flag_word[51], 1'b1);
         apb(1'b1, EEX_OFF_FLAGS, 32'h0000_0000);
      end
      apb(1'b0, EEX_OFF_RCOND, 32'h0000_0000);
      chk("hw cond reg", rd, {10'h000, EEX_CODE_HW_B, 16'h0000});
      ev(6'h00, 5'h08);
      lag();
      chk("cif set", xp_flag_word[53], 1'b1);
      cmu_state <= 32'h0000_0000;
      ev(6'h00, 5'h10);
      chk("resume", cmu_resume, 1'b1);
      chk("resume state", cmu_resume_state, 32'h1234_5678);
      repeat (2) lag();
      chk("cif clear", xp_flag_word[53], 1'b0);
      summarize();
   end
endmodule
